/* counter_array_pkg.sv */
package counter_array_pkg;

  // sizes
  localparam int unsigned NUM_MODULES = 6;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // special-function addresses
  localparam logic [7:0] ADDR_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_OVF_ENABLE = 8'hd9;
  localparam logic [7:0] ADDR_MODE_BASE = 8'hda;
  localparam logic [7:0] ADDR_CMP_LOW_BASE = 8'he9;
  localparam logic [7:0] ADDR_CMP_HIGH_BASE = 8'hf9;
  localparam logic [7:0] ADDR_CNT_LOW = 8'hf7;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'hf8;

  // control register fields
  localparam int unsigned CTRL_OVF_BIT = 7;
  localparam int unsigned CTRL_RUN_BIT = 6;
  localparam int unsigned CTRL_FLAG_LSB = 0;

  // module mode register fields
  localparam int unsigned MODE_COMPARATOR_EN = 6;
  localparam int unsigned MODE_MATCH_EN = 3;
  localparam int unsigned MODE_TOGGLE_EN = 2;
  localparam int unsigned MODE_INT_EN = 0;

  // overflow interrupt enable register field
  localparam int unsigned OVF_INT_EN_BIT = 0;

  // reset values and counter limits
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

endpackage : counter_array_pkg

/* compare_module.sv */
`timescale 1ns/1ps
module compare_module
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [counter_array_pkg::CNT_W-1:0] cnt_value,
  input wire logic cnt_step,
  input wire logic wr_mode,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [counter_array_pkg::DATA_W-1:0] wdata,
  output logic [counter_array_pkg::DATA_W-1:0] mode_value,
  output logic [counter_array_pkg::CNT_W-1:0] cmp_value,
  output logic compare_output_pin,
  output logic match_hit,
  output logic toggle_hit
);
  import counter_array_pkg::*;

  logic [DATA_W-1:0] mode_ff;
  logic [DATA_W-1:0] nxt_mode;
  logic [CNT_W-1:0] cmp_ff;
  logic [CNT_W-1:0] nxt_cmp;
  logic pin_ff;
  wire comparator_enable = mode_ff[MODE_COMPARATOR_EN];
  wire match_enable = mode_ff[MODE_MATCH_EN];
  wire toggle_enable = mode_ff[MODE_TOGGLE_EN];

  // match uses the stored value, so a same-cycle write waits a cycle
  // [R15] only while counting
  assign match_hit = cnt_step && comparator_enable && match_enable && (cnt_value == cmp_ff);
  // [R5] all three enables
  assign toggle_hit = match_hit && toggle_enable;

  // mode byte with compare-write side effects
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_cmp = cmp_ff;
    if (wr_mode)
    begin
      nxt_mode = wdata;
    end
    // [R7] low write disables
    if (wr_low)
    begin
      nxt_cmp[DATA_W-1:0] = wdata;
      nxt_mode[MODE_COMPARATOR_EN] = 1'b0;
    end
    // [R8] high write enables
    if (wr_high)
    begin
      nxt_cmp[CNT_W-1:DATA_W] = wdata;
      nxt_mode[MODE_COMPARATOR_EN] = 1'b1;
    end
  end

  // state, pin holds unless toggled
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_ff <= RESET_BYTE;
      cmp_ff <= {RESET_BYTE, RESET_BYTE};
      pin_ff <= 1'b0;
    end
    else if (ce)
    begin
      mode_ff <= nxt_mode;
      cmp_ff <= nxt_cmp;
      // [R1] invert on match, [R6] hold otherwise
      pin_ff <= pin_ff ^ toggle_hit;
    end
  end

  assign mode_value = mode_ff;
  assign cmp_value = cmp_ff;
  assign compare_output_pin = pin_ff;

endmodule : compare_module

/* counter_array_toggle_output.sv */
`timescale 1ns/1ps
// What this block does
// [R1] In toggle mode, a module's output pin inverts whenever counter equals its compare value.
// [R2] A compare match sets that module's flag in the shared control register.
// [R3] A set module flag with its interrupt enabled raises the interrupt request.
// [R4] Hardware never clears module flags on vectoring; software clears them.
// [R5] Toggle mode needs toggle, match and comparator enable bits all set.
// [R6] Comparator enable clear holds the pin and skips the next toggle.
// [R7] Writing a compare low byte clears that module's comparator enable.
// [R8] Writing a compare high byte sets that module's comparator enable.
// [R9] Software should write low byte before high byte.
// [R10] Counter wrapping from all ones to zero sets the overflow flag.
// [R11] Overflow flag with its enable requests interrupt; only software clears it.
// [R12] Run control bit 6 stops the counter at 0, runs it at 1.
// [R13] Control register is bit-addressable: overflow bit 7, run 6, flags 5..0.
// [R14] A module capture also sets that module's flag.
// [R15] Matches count only while running; same-cycle compare write uses old value.
module counter_array_toggle_output
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic cnt_tick,
  input wire logic [counter_array_pkg::NUM_MODULES-1:0] capture_event,
  input wire logic [counter_array_pkg::ADDR_W-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [counter_array_pkg::DATA_W-1:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [counter_array_pkg::ADDR_W-1:0] sfr_bit_addr,
  input wire logic sfr_bit_wdata,
  output logic [counter_array_pkg::DATA_W-1:0] sfr_rdata,
  output logic [counter_array_pkg::NUM_MODULES-1:0] compare_output_pin,
  output logic irq_req
);
  import counter_array_pkg::*;

  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] nxt_ctrl;
  logic ovf_en_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [NUM_MODULES-1:0] hit;
  logic [NUM_MODULES-1:0] toggle_hit;
  logic [NUM_MODULES-1:0] wr_low_v;
  logic [NUM_MODULES-1:0] wr_high_v;
  logic [NUM_MODULES-1:0] int_en_v;
  logic [NUM_MODULES-1:0] cmp_en_v;
  logic [NUM_MODULES-1:0] mat_en_v;
  logic [NUM_MODULES-1:0] tog_en_v;
  logic [DATA_W-1:0] mode_arr [NUM_MODULES];
  logic [CNT_W-1:0] cmp_arr [NUM_MODULES];
  logic [DATA_W-1:0] module_rd [NUM_MODULES];
  logic [NUM_MODULES-1:0] module_rd_hit;

  // counter step and wrap
  // [R12] run bit gates counting
  wire run = ctrl_ff[CTRL_RUN_BIT];
  wire cnt_step = run && cnt_tick;
  wire cnt_wrap = cnt_step && (cnt_ff == CNT_MAX);

  // control and overflow enable register access decode
  wire ctrl_byte_wr = sfr_wr && (sfr_addr == ADDR_CONTROL);
  wire ctrl_bit_wr = sfr_bit_wr && (sfr_bit_addr[ADDR_W-1:3] == ADDR_CONTROL[ADDR_W-1:3]);
  wire [2:0] ctrl_bit_idx = sfr_bit_addr[2:0];
  wire ovf_en_wr = sfr_wr && (sfr_addr == ADDR_OVF_ENABLE);
  wire ctrl_sw_wr = ctrl_byte_wr || ctrl_bit_wr;

  // per-module instances and their decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MODULES; gi++)
    begin : g_mod
      wire [ADDR_W-1:0] a_mode = ADDR_MODE_BASE + ADDR_W'(gi);
      wire [ADDR_W-1:0] a_low = ADDR_CMP_LOW_BASE + ADDR_W'(gi);
      wire [ADDR_W-1:0] a_high = ADDR_CMP_HIGH_BASE + ADDR_W'(gi);
      wire wr_mode = sfr_wr && (sfr_addr == a_mode);
      assign wr_low_v[gi] = sfr_wr && (sfr_addr == a_low);
      assign wr_high_v[gi] = sfr_wr && (sfr_addr == a_high);
      compare_module u_cmp
      (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .cnt_value(cnt_ff),
        .cnt_step(cnt_step),
        .wr_mode(wr_mode),
        .wr_low(wr_low_v[gi]),
        .wr_high(wr_high_v[gi]),
        .wdata(sfr_wdata),
        .mode_value(mode_arr[gi]),
        .cmp_value(cmp_arr[gi]),
        .compare_output_pin(compare_output_pin[gi]),
        .match_hit(hit[gi]),
        .toggle_hit(toggle_hit[gi])
      );
      assign int_en_v[gi] = mode_arr[gi][MODE_INT_EN];
      assign cmp_en_v[gi] = mode_arr[gi][MODE_COMPARATOR_EN];
      assign mat_en_v[gi] = mode_arr[gi][MODE_MATCH_EN];
      assign tog_en_v[gi] = mode_arr[gi][MODE_TOGGLE_EN];
      assign module_rd_hit[gi] = (sfr_addr == a_mode) || (sfr_addr == a_low) || (sfr_addr == a_high);
      assign module_rd[gi] = (sfr_addr == a_mode) ? mode_arr[gi] :
                             (sfr_addr == a_low) ? cmp_arr[gi][DATA_W-1:0] :
                             (sfr_addr == a_high) ? cmp_arr[gi][CNT_W-1:DATA_W] : RESET_BYTE;
    end
  endgenerate

  // hardware sets applied after software writes, so a set always wins
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    // [R13] byte or single-bit write
    if (ctrl_byte_wr)
    begin
      nxt_ctrl = sfr_wdata;
    end
    else if (ctrl_bit_wr)
    begin
      nxt_ctrl[ctrl_bit_idx] = sfr_bit_wdata;
    end
    // [R2] match sets flag, [R14] capture too
    nxt_ctrl[CTRL_FLAG_LSB +: NUM_MODULES] = nxt_ctrl[CTRL_FLAG_LSB +: NUM_MODULES] | hit | capture_event;
    // [R10] wrap sets overflow flag
    if (cnt_wrap)
    begin
      nxt_ctrl[CTRL_OVF_BIT] = 1'b1;
    end
  end

  // read mux, registered data
  always_comb
  begin
    nxt_rdata = RESET_BYTE;
    if (sfr_addr == ADDR_CONTROL)
    begin
      nxt_rdata = ctrl_ff;
    end
    else if (sfr_addr == ADDR_OVF_ENABLE)
    begin
      nxt_rdata[OVF_INT_EN_BIT] = ovf_en_ff;
    end
    else if (sfr_addr == ADDR_CNT_LOW)
    begin
      nxt_rdata = cnt_ff[DATA_W-1:0];
    end
    else if (sfr_addr == ADDR_CNT_HIGH)
    begin
      nxt_rdata = cnt_ff[CNT_W-1:DATA_W];
    end
    for (int k = 0; k < NUM_MODULES; k++)
    begin
      if (module_rd_hit[k])
      begin
        nxt_rdata = module_rd[k];
      end
    end
  end

  // shared state, frozen while ce is low
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_ff <= RESET_BYTE;
      ovf_en_ff <= 1'b0;
      cnt_ff <= CNT_ZERO;
      rdata_ff <= RESET_BYTE;
    end
    else if (ce)
    begin
      // [R4] flags only change by software or hardware set
      ctrl_ff <= nxt_ctrl;
      ovf_en_ff <= ovf_en_wr ? sfr_wdata[OVF_INT_EN_BIT] : ovf_en_ff;
      cnt_ff <= cnt_step ? (cnt_ff + CNT_ONE) : cnt_ff;
      rdata_ff <= sfr_rd ? nxt_rdata : rdata_ff;
    end
  end

  // interrupt request level
  // [R3] module flags, [R11] overflow flag
  assign irq_req = (ctrl_ff[CTRL_OVF_BIT] && ovf_en_ff) ||
                   (|(ctrl_ff[CTRL_FLAG_LSB +: NUM_MODULES] & int_en_v));
  assign sfr_rdata = rdata_ff;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // flag bits only, run control excluded
  wire [DATA_W-1:0] sticky_mask = ~(DATA_W'(1) << CTRL_RUN_BIT);

  chk_pin_toggle: assert property (ce |=> compare_output_pin == ($past(compare_output_pin) ^ $past(toggle_hit))) // [R1]
    else $error("pin did not follow match toggles");
  chk_match_flag: assert property (ce && (|hit) |=> (ctrl_ff[CTRL_FLAG_LSB +: NUM_MODULES] & $past(hit)) == $past(hit)) // [R2]
    else $error("match flag not set");
  chk_flag_irq: assert property (ce && (|(hit & int_en_v)) |=> irq_req) // [R3]
    else $error("no interrupt after enabled match");
  chk_flag_sticky: assert property (ce && !ctrl_sw_wr |=>
      (ctrl_ff & $past(ctrl_ff) & sticky_mask) == ($past(ctrl_ff) & sticky_mask)) // [R4]
    else $error("flag cleared without software write");
  chk_toggle_gate: assert property ((toggle_hit & ~(cmp_en_v & mat_en_v & tog_en_v)) == '0) // [R5]
    else $error("toggle without all three enables");
  chk_hold_disabled: assert property (ce |=> ((compare_output_pin ^ $past(compare_output_pin)) & ~$past(cmp_en_v)) == '0) // [R6]
    else $error("pin moved with comparators off");
  chk_low_clears: assert property (ce && (|wr_low_v) |=> (cmp_en_v & $past(wr_low_v)) == '0) // [R7]
    else $error("low write left comparator enabled");
  chk_high_sets: assert property (ce && (|wr_high_v) |=> (cmp_en_v & $past(wr_high_v)) == $past(wr_high_v)) // [R8]
    else $error("high write did not enable comparator");
  chk_ovf_wrap: assert property (ce && cnt_wrap |=> ctrl_ff[CTRL_OVF_BIT] && cnt_ff == CNT_ZERO) // [R10]
    else $error("wrap did not set overflow flag");
  chk_ovf_irq: assert property (ctrl_ff[CTRL_OVF_BIT] && ovf_en_ff |-> irq_req) // [R11]
    else $error("overflow interrupt missing");
  chk_run_stop: assert property (!run |=> cnt_ff == $past(cnt_ff)) // [R12]
    else $error("counter moved while stopped");
  chk_bit_write: assert property (ce && ctrl_bit_wr && !ctrl_byte_wr && ctrl_bit_idx == 3'(CTRL_RUN_BIT)
      |=> run == $past(sfr_bit_wdata)) // [R13]
    else $error("bit write to run control lost");
  chk_capture_flag: assert property (ce && (|capture_event) |=>
      (ctrl_ff[CTRL_FLAG_LSB +: NUM_MODULES] & $past(capture_event)) == $past(capture_event)) // [R14]
    else $error("capture did not set flag");
  chk_no_match_stopped: assert property (!run |-> hit == '0) // [R15]
    else $error("match while counter stopped");

  cov_toggle: cover property (ce && (|toggle_hit) ##1 ce && (|toggle_hit));
  cov_wrap: cover property (ce && cnt_wrap);
  cov_reload: cover property (ce && (|wr_low_v) ##[1:4] ce && (|wr_high_v));

endmodule : counter_array_toggle_output

/* pin_watch.sv */
`timescale 1ns/1ps
// far-side load on the toggle pins: counts every level change per pin
module pin_watch
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [5:0] pins,
  output logic [5:0][7:0] edges
);
  logic [5:0] last_ff;

  always_ff @(posedge clk_sys)
  begin
    last_ff <= pins;
    for (int i = 0; i < 6; i++)
    begin
      if (srst)
        edges[i] <= 8'h00;
      else if (pins[i] !== last_ff[i])
        edges[i] <= edges[i] + 8'h01;
    end
  end
endmodule : pin_watch

/* tb_counter_array_toggle_output.sv */
`timescale 1ns/1ps
module tb_counter_array_toggle_output;
  import counter_array_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic cnt_tick = 1'b0;
  logic [5:0] capture_event = 6'h00;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_bit_wr = 1'b0;
  logic [7:0] sfr_bit_addr = 8'h00;
  logic sfr_bit_wdata = 1'b0;
  logic [7:0] sfr_rdata;
  logic [5:0] compare_output_pin;
  logic irq_req;
  logic [5:0][7:0] edges;
  logic [7:0] rd_val;
  int err_count = 0;
  int n_compared = 0;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  counter_array_toggle_output uut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .cnt_tick(cnt_tick),
    .capture_event(capture_event), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wdata(sfr_bit_wdata), .sfr_rdata(sfr_rdata), .compare_output_pin(compare_output_pin),
    .irq_req(irq_req));

  pin_watch load (.clk_sys(clk_sys), .srst(srst), .pins(compare_output_pin), .edges(edges));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic bit_wr(input logic [7:0] a, input logic v);
    @(posedge clk_sys);
    sfr_bit_addr <= a;
    sfr_bit_wdata <= v;
    sfr_bit_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_bit_wr <= 1'b0;
  endtask : bit_wr

  // read result lands one cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1;
    check({8'h00, sfr_rdata}, {8'h00, exp}, what);
  endtask : rd_chk

  // counter advances once per sampled tick
  task automatic step(input int n);
    @(posedge clk_sys);
    cnt_tick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    cnt_tick <= 1'b0;
    #1;
  endtask : step

  task automatic test_toggle;
    rd_chk(8'hd8, 8'h00, "control reset");
    wr(8'hda, 8'h4d);
    wr(8'hdb, 8'h48);
    wr(8'he9, 8'h05);
    rd_chk(8'hda, 8'h0d, "low write clears cmp enable");
    wr(8'hf9, 8'h00);
    rd_chk(8'hda, 8'h4d, "high write sets cmp enable");
    wr(8'hea, 8'h05);
    wr(8'hfa, 8'h00);
    bit_wr(8'hde, 1'b1);
    step(6);
    check(16'(compare_output_pin[0]), 16'h1, "pin0 toggled");
    check(16'(compare_output_pin[1]), 16'h0, "pin1 without toggle enable");
    rd_chk(8'hd8, 8'h43, "match flags");
    check(16'(irq_req), 16'h1, "match irq");
    $display("test_toggle done");
  endtask : test_toggle

  task automatic test_hold;
    wr(8'he9, 8'h08);
    step(5);
    check(16'(compare_output_pin[0]), 16'h1, "pin held");
    wr(8'he9, 8'h0c);
    wr(8'hf9, 8'h00);
    step(2);
    check(16'(compare_output_pin[0]), 16'h0, "pin toggled back");
    rd_chk(8'hd8, 8'h43, "flags sticky");
    check(16'(edges[0]), 16'h2, "load saw two edges");
    rd_chk(8'he9, 8'h0c, "compare low readback");
    wr(8'hd8, 8'h40);
    rd_chk(8'hd8, 8'h40, "flags cleared");
    check(16'(irq_req), 16'h0, "irq dropped");
    $display("test_hold done");
  endtask : test_hold

  task automatic test_capture;
    @(posedge clk_sys);
    capture_event <= 6'h08;
    @(posedge clk_sys);
    capture_event <= 6'h00;
    rd_chk(8'hd8, 8'h48, "capture flag");
    check(16'(irq_req), 16'h0, "capture irq masked");
    wr(8'hdd, 8'h01);
    #1;
    check(16'(irq_req), 16'h1, "capture irq enabled");
    // clear and capture in one cycle: the hardware set must win
    @(posedge clk_sys);
    sfr_addr <= 8'hd8;
    sfr_wdata <= 8'h40;
    sfr_wr <= 1'b1;
    capture_event <= 6'h04;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    capture_event <= 6'h00;
    rd_chk(8'hd8, 8'h44, "capture beats clear");
    check(16'(irq_req), 16'h0, "cleared flag irq gone");
    wr(8'hd8, 8'h40);
    bit_wr(8'hde, 1'b0);
    step(4);
    rd_chk(8'hf7, 8'h0d, "stopped counter");
    bit_wr(8'hde, 1'b1);
    rd_chk(8'h00, 8'h00, "unmapped read");
    $display("test_capture done");
  endtask : test_capture

  task automatic test_overflow;
    wr(8'hd9, 8'h01);
    rd_chk(8'hd9, 8'h01, "overflow enable readback");
    step(65522);
    rd_chk(8'hf7, 8'hff, "counter low at max");
    rd_chk(8'hf8, 8'hff, "counter high at max");
    rd_chk(8'hd8, 8'h40, "no overflow yet");
    step(1);
    rd_chk(8'hd8, 8'hc0, "overflow flag");
    check(16'(irq_req), 16'h1, "overflow irq");
    step(3);
    rd_chk(8'hd8, 8'hc0, "overflow sticky");
    bit_wr(8'hdf, 1'b0);
    rd_chk(8'hd8, 8'h40, "overflow cleared");
    check(16'(irq_req), 16'h0, "overflow irq gone");
    $display("test_overflow done");
  endtask : test_overflow

  // clock enable low freezes everything, then a mid-run reset clears it
  task automatic test_freeze_reset;
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(8'hd8, 8'h00);
    step(10);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk(8'hf7, 8'h03, "counter frozen");
    rd_chk(8'hd8, 8'h40, "write ignored while frozen");
    check(16'(compare_output_pin[0]), 16'h0, "pin frozen");
    step(10);
    check(16'(compare_output_pin[0]), 16'h1, "pin0 toggled after freeze");
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd_chk(8'hd8, 8'h00, "control after reset");
    rd_chk(8'hf7, 8'h00, "counter after reset");
    check(16'(compare_output_pin), 16'h0, "pins after reset");
    check(16'(irq_req), 16'h0, "irq after reset");
    $display("test_freeze_reset done");
  endtask : test_freeze_reset

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // watchdog against a hung run
  initial
  begin
    #(50 * 90000);
    err_count++;
    $display("MISMATCH t=%0t run timed out", $time);
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    test_toggle();
    test_hold();
    test_capture();
    test_overflow();
    test_freeze_reset();
    tally_and_finish();
  end
endmodule : tb_counter_array_toggle_output
